// file: hdl/utx_transmitter.sv
// uart transmit path: two-entry holding buffer, shift register, line format control
// assumes a register master that never reads and writes in one cycle
// Overview of operation
// - holding buffer keeps bytes apart from the byte being shifted
// - every byte written while fewer than two are held goes to the shifter, and onto the serial pin unless break is set
// - dma, not the processor, writes transmit bytes in normal operation
// - eight-bit write-only transmit byte location, reset value zero
// - line format register selects word length, stop bits, parity
// - format bits: flow, break, forced parity, even, enable, stop, length
// - stop select cleared gives one stop bit for all lengths
module utx_transmitter (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    output logic             txReady,
    output logic             serialOutPin,
    output logic             flowEnableBit
);
    logic [7:0]  formatReg, formatNext;
    logic [15:0] divReg, divNext;
    logic [7:0]  rdReg, rdNext;
    logic [7:0]  bufReg [2];
    logic [7:0]  bufNext [2];
    logic [1:0]  cntReg, cntNext;
    logic        rdPtrReg, rdPtrNext, wrPtrReg, wrPtrNext;
    logic        readyReg, readyNext;
    utx_pkg::utx_state_t stReg, stNext;
    logic [7:0]  shiftReg, shiftNext;
    logic [2:0]  bitReg, bitNext;
    logic [15:0] baudReg, baudNext;
    logic        halfReg, halfNext;
    logic        parReg, parNext;
    logic        outReg, outNext;
    logic        tick, bufPush, bufPop;
    logic [3:0]  wordLen;
    logic        twoStop;
    assign tick    = (baudReg == 16'h0000);
    assign wordLen = utx_pkg::WORD_LENGTH_BASE + {2'h0, formatReg[1:0]};
    assign twoStop = formatReg[utx_pkg::STOP_SELECT_POS];
    assign bufPush = regWrite && (regAddr == utx_pkg::TRANSMIT_BYTE_ADDR) && (cntReg != 2'h2);
    assign bufPop  = (stReg == utx_pkg::ST_IDLE) && (cntReg != 2'h0);
    always_comb begin
        formatNext = formatReg;
        divNext    = divReg;
        rdNext     = 8'h00;
        if (regWrite && regAddr == utx_pkg::LINE_FORMAT_CONTROL_ADDR) begin
            formatNext = regWrData;
        end
        if (regWrite && regAddr == utx_pkg::BAUD_DIVISOR_ADDR) begin
            divNext = {8'h00, regWrData};
        end
        if (regRead && regAddr == utx_pkg::LINE_FORMAT_CONTROL_ADDR) begin
            rdNext = formatReg;
        end else if (regRead && regAddr == utx_pkg::BAUD_DIVISOR_ADDR) begin
            rdNext = divReg[7:0];
        end
    end
    always_comb begin
        bufNext[0] = bufReg[0];
        bufNext[1] = bufReg[1];
        wrPtrNext  = wrPtrReg;
        rdPtrNext  = rdPtrReg;
        cntNext    = cntReg;
        if (bufPush) begin
            bufNext[wrPtrReg] = regWrData;
            wrPtrNext = ~wrPtrReg;
        end
        if (bufPop) begin
            rdPtrNext = ~rdPtrReg;
        end
        cntNext   = cntReg + (bufPush ? 2'h1 : 2'h0) - (bufPop ? 2'h1 : 2'h0);
        readyNext = (cntNext != 2'h2);
    end
    always_comb begin
        stNext    = stReg;
        shiftNext = shiftReg;
        bitNext   = bitReg;
        baudNext  = tick ? divReg : baudReg - 16'h0001;
        halfNext  = halfReg;
        parNext   = parReg;
        outNext   = outReg;
        unique case (stReg)
            utx_pkg::ST_IDLE: begin
                outNext = 1'b1;
                if (bufPop) begin
                    shiftNext = bufReg[rdPtrReg];
                    parNext   = 1'b0;
                    bitNext   = 3'h0;
                    baudNext  = divReg;
                    outNext   = 1'b0;
                    stNext    = utx_pkg::ST_START;
                end
            end
            utx_pkg::ST_START: begin
                if (tick) begin
                    outNext = shiftReg[0];
                    parNext = shiftReg[0];
                    stNext  = utx_pkg::ST_DATA;
                end
            end
            utx_pkg::ST_DATA: begin
                if (tick) begin
                    shiftNext = {1'b0, shiftReg[7:1]};
                    if ({1'b0, bitReg} == wordLen - 4'h1) begin
                        halfNext = 1'b0;
                        if (formatReg[utx_pkg::PARITY_ENABLE_POS]) begin
                            stNext = utx_pkg::ST_PARITY;
                            if (formatReg[utx_pkg::FORCED_PARITY_POS]) begin
                                outNext = ~formatReg[utx_pkg::EVEN_PARITY_POS];
                            end else begin
                                outNext = parReg ^ ~formatReg[utx_pkg::EVEN_PARITY_POS];
                            end
                        end else begin
                            stNext  = utx_pkg::ST_STOP;
                            outNext = 1'b1;
                        end
                    end else begin
                        bitNext = bitReg + 3'h1;
                        outNext = shiftReg[1];
                        parNext = parReg ^ shiftReg[1];
                    end
                end
            end
            utx_pkg::ST_PARITY: begin
                if (tick) begin
                    outNext = 1'b1;
                    stNext  = utx_pkg::ST_STOP;
                end
            end
            utx_pkg::ST_STOP: begin
                if (tick) begin
                    if (twoStop && !halfReg) begin
                        halfNext = 1'b1;
                    end else begin
                        stNext = utx_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            formatReg <= utx_pkg::LINE_FORMAT_RESET;
            divReg    <= utx_pkg::BAUD_DIVISOR_RESET;
            rdReg     <= 8'h00;
            bufReg[0] <= utx_pkg::TRANSMIT_BYTE_RESET;
            bufReg[1] <= utx_pkg::TRANSMIT_BYTE_RESET;
            cntReg    <= 2'h0;
            wrPtrReg  <= 1'b0;
            rdPtrReg  <= 1'b0;
            readyReg  <= 1'b1;
            stReg     <= utx_pkg::ST_IDLE;
            shiftReg  <= 8'h00;
            bitReg    <= 3'h0;
            baudReg   <= 16'h0000;
            halfReg   <= 1'b0;
            parReg    <= 1'b0;
            outReg    <= 1'b1;
        end else begin
            formatReg <= formatNext;
            divReg    <= divNext;
            rdReg     <= rdNext;
            bufReg    <= bufNext;
            cntReg    <= cntNext;
            wrPtrReg  <= wrPtrNext;
            rdPtrReg  <= rdPtrNext;
            readyReg  <= readyNext;
            stReg     <= stNext;
            shiftReg  <= shiftNext;
            bitReg    <= bitNext;
            baudReg   <= baudNext;
            halfReg   <= halfNext;
            parReg    <= parNext;
            outReg    <= outNext;
        end
    end
    // break forces the line low without disturbing the shifter
    logic pinReg;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pinReg <= 1'b1;
        end else begin
            pinReg <= outNext & ~formatNext[utx_pkg::LINE_BREAK_POS];
        end
    end
    assign serialOutPin  = pinReg;
    assign regRdData     = rdReg;
    assign txReady       = readyReg;
    assign flowEnableBit = formatReg[utx_pkg::FLOW_ENABLE_POS];
    property p_buffer_bound;
        @(posedge clock) disable iff (sys_rst) cntReg <= 2'h2;
    endproperty
    a_buffer_bound: assert property (p_buffer_bound) else $error("buffer overfilled");
    property p_load_when_idle;
        @(posedge clock) disable iff (sys_rst)
            (stReg == utx_pkg::ST_START) && $past(stReg == utx_pkg::ST_IDLE)
            |-> $past(cntReg != 2'h0);
    endproperty
    a_load_when_idle: assert property (p_load_when_idle) else $error("load without byte");
    property p_start_low;
        @(posedge clock) disable iff (sys_rst)
            $rose(stReg == utx_pkg::ST_START) && !formatReg[utx_pkg::LINE_BREAK_POS]
            |=> !serialOutPin;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");
    property p_format_read;
        @(posedge clock) disable iff (sys_rst)
            regRead && regAddr == utx_pkg::LINE_FORMAT_CONTROL_ADDR
            |=> regRdData == $past(formatReg);
    endproperty
    a_format_read: assert property (p_format_read) else $error("format readback wrong");
    property p_byte_reads_zero;
        @(posedge clock) disable iff (sys_rst)
            regRead && regAddr == utx_pkg::TRANSMIT_BYTE_ADDR |=> regRdData == 8'h00;
    endproperty
    a_byte_reads_zero: assert property (p_byte_reads_zero) else $error("write-only read");
    property p_format_write;
        @(posedge clock) disable iff (sys_rst)
            regWrite && regAddr == utx_pkg::LINE_FORMAT_CONTROL_ADDR
            |=> formatReg == $past(regWrData);
    endproperty
    a_format_write: assert property (p_format_write) else $error("format not stored");
    property p_one_stop;
        @(posedge clock) disable iff (sys_rst)
            stReg == utx_pkg::ST_STOP && tick && !twoStop |=> stReg == utx_pkg::ST_IDLE;
    endproperty
    a_one_stop: assert property (p_one_stop) else $error("extra stop bit");
    property p_ready_full;
        @(posedge clock) disable iff (sys_rst) txReady == (cntReg != 2'h2);
    endproperty
    a_ready_full: assert property (p_ready_full) else $error("ready wrong");
    // a write while both entries are taken must leave the held bytes alone
    sequence s_full_write;
        regWrite && regAddr == utx_pkg::TRANSMIT_BYTE_ADDR && cntReg == 2'h2
            && stReg != utx_pkg::ST_IDLE;
    endsequence
    property p_refused_write;
        @(posedge clock) disable iff (sys_rst)
            s_full_write |=> cntReg == 2'h2 && bufReg[0] == $past(bufReg[0])
                && bufReg[1] == $past(bufReg[1]);
    endproperty
    a_refused_write: assert property (p_refused_write) else $error("refused byte stored");
endmodule

// file: shared/utx_pkg.sv
// constants for the uart transmit data path and line format control
// assumes a single 250 MHz clock and a plain strobed register port
package utx_pkg;
    localparam logic [15:0] TRANSMIT_BYTE_ADDR       = 16'hffa1;
    localparam logic [15:0] LINE_FORMAT_CONTROL_ADDR = 16'hffa2;
    localparam logic [15:0] BAUD_DIVISOR_ADDR        = 16'hffb0;
    localparam logic [7:0]  TRANSMIT_BYTE_RESET      = 8'h00;
    localparam logic [7:0]  LINE_FORMAT_RESET        = 8'h00;
    localparam logic [15:0] BAUD_DIVISOR_RESET       = 16'h0010;
    localparam int FLOW_ENABLE_POS    = 7;
    localparam int LINE_BREAK_POS     = 6;
    localparam int FORCED_PARITY_POS  = 5;
    localparam int EVEN_PARITY_POS    = 4;
    localparam int PARITY_ENABLE_POS  = 3;
    localparam int STOP_SELECT_POS    = 2;
    localparam int WORD_LENGTH_HI_POS = 1;
    localparam int WORD_LENGTH_LO_POS = 0;
    localparam logic [3:0]  WORD_LENGTH_BASE = 4'h5;
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_START  = 5'h02,
        ST_DATA   = 5'h04,
        ST_PARITY = 5'h08,
        ST_STOP   = 5'h10
    } utx_state_t;
endpackage

// file: tb/utx_serial_sink.sv
// serial line sink: samples the transmit pin at mid-bit and reports each frame
// assumes a bit time of four clocks and a format set while the line is idle
module utx_serial_sink (
    input  wire logic       clock,
    input  wire logic       serialIn,
    input  wire logic [3:0] nBits,
    input  wire logic       parityOn,
    input  wire logic       twoStop,
    output logic            rxValid,
    output logic [7:0]      rxData,
    output logic            rxPar,
    output logic            rxStopOk
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYCLES = 4;
    task automatic bitWait(input int n);
        repeat (n) @(posedge clock);
    endtask
    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        rxPar = 1'b0;
        rxStopOk = 1'b0;
        forever begin
            @(negedge serialIn);
            bitWait(BIT_CYCLES / 2);
            rxData = 8'h00;
            for (int i = 0; i < 8; i++) begin
                if (i < nBits) begin
                    bitWait(BIT_CYCLES);
                    rxData[i] = serialIn;
                end
            end
            if (parityOn) begin
                bitWait(BIT_CYCLES);
                rxPar = serialIn;
            end
            bitWait(BIT_CYCLES);
            rxStopOk = serialIn;
            // a second stop bit must also be high, not merely idle later
            if (twoStop) begin
                bitWait(BIT_CYCLES);
                rxStopOk = rxStopOk & serialIn;
            end
            rxValid <= 1'b1;
            @(posedge clock);
            rxValid <= 1'b0;
        end
    end
endmodule

// file: tb/utx_transmitter_bench.sv
// bench for the uart transmit path: register driver, random formats, frame checks
// assumes divisor 3, so one bit lasts four clocks of 4 ns
module utx_transmitter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, sys_rst, regWrite, regRead, txReady, serialOutPin;
    logic        flowEnableBit, rxValid, rxPar, rxStopOk, inBreak;
    logic [15:0] regAddr;
    logic [7:0]  regWrData, regRdData, rxData, lcrCur;
    logic [31:0] seed;
    int          fails, n_tests;
    logic [7:0]  expQ[$];

    utx_transmitter u_dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .txReady(txReady), .serialOutPin(serialOutPin),
        .flowEnableBit(flowEnableBit));
    utx_serial_sink u_sink (.clock(clock), .serialIn(serialOutPin),
        .nBits(utx_pkg::WORD_LENGTH_BASE + {2'h0, lcrCur[1:0]}),
        .parityOn(lcrCur[3]), .twoStop(lcrCur[2]), .rxValid(rxValid),
        .rxData(rxData), .rxPar(rxPar), .rxStopOk(rxStopOk));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] wordMask(input logic [7:0] line_format_control);
        return 8'hff >> (2'h3 - line_format_control[1:0]);
    endfunction
    function automatic logic expParity(input logic [7:0] line_format_control, input logic [7:0] d);
        if (line_format_control[5]) return ~line_format_control[4];
        return line_format_control[4] ? ^d : ~^d;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWrData <= d;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1;
        check(regRdData, exp);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (40000) @(posedge clock);
        fails++;
        test_done();
    end
    always @(posedge clock) begin
        logic [7:0] e;
        if (rxValid && !inBreak) begin
            e = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
            e = e & wordMask(lcrCur);
            check(rxData, e);
            check({7'h0, rxStopOk}, 8'h01);
            if (lcrCur[3]) check({7'h0, rxPar}, {7'h0, expParity(lcrCur, e)});
        end
    end
    initial begin
        {seed, fails, n_tests, inBreak, lcrCur} = {32'hd209, 64'h0, 1'b0, 8'h00};
        {sys_rst, regWrite, regRead, regAddr, regWrData} = {3'b100, 24'h0};
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        #1;
        check({5'h0, txReady, serialOutPin, flowEnableBit}, 8'h06);
        rd(utx_pkg::LINE_FORMAT_CONTROL_ADDR, utx_pkg::LINE_FORMAT_RESET);
        rd(utx_pkg::TRANSMIT_BYTE_ADDR, 8'h00);
        rd(16'h1234, 8'h00);
        bus(1'b1, 1'b0, utx_pkg::BAUD_DIVISOR_ADDR, 8'h03);
        for (int r = 0; r < 16; r++) begin
            seed = xorshift(seed);
            // low three bits walk every length and stop choice, parity bits random
            lcrCur = (seed[7:0] & 8'hb8) | {5'h0, r[2:0]};
            bus(1'b1, 1'b0, utx_pkg::LINE_FORMAT_CONTROL_ADDR, lcrCur);
            rd(utx_pkg::LINE_FORMAT_CONTROL_ADDR, lcrCur);
            check({7'h0, flowEnableBit}, {7'h0, lcrCur[7]});
            for (int j = 0; j < 6; j++) begin
                if (j > 1) begin
                    bus(1'b0, 1'b0, 16'h0000, 8'h00);
                    #1;
                    if (!txReady) break;
                end
                seed = xorshift(seed);
                bus(1'b1, 1'b0, utx_pkg::TRANSMIT_BYTE_ADDR, seed[15:8]);
                expQ.push_back(seed[15:8]);
            end
            check({7'h0, txReady}, 8'h00);
            // refused write: must never reach the line
            bus(1'b1, 1'b0, utx_pkg::TRANSMIT_BYTE_ADDR, 8'h5a);
            bus(1'b0, 1'b0, 16'h0000, 8'h00);
            for (int k = 0; k < 3000 && expQ.size() > 0; k++) @(posedge clock);
            check(8'(expQ.size()), 8'h00);
            repeat (16) @(posedge clock);
        end
        inBreak = 1'b1;
        bus(1'b1, 1'b0, utx_pkg::LINE_FORMAT_CONTROL_ADDR, 8'hc0);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge clock);
        #1;
        check({6'h0, serialOutPin, flowEnableBit}, 8'h01);
        bus(1'b1, 1'b0, utx_pkg::LINE_FORMAT_CONTROL_ADDR, 8'h00);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge clock);
        #1;
        check({6'h0, serialOutPin, flowEnableBit}, 8'h02);
        test_done();
    end
endmodule
